// file: logic/nbm_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "nbm_cfg.svh"

// Functional notes
// - Chip select high over 100 ns ends read
// - Block zero always good, no ECC needed
// - Non-FF marker in page 0/1 means bad
// - Build table from markers, never erase them
// - Remap so bad blocks are never accessed
// - Check status; failed block gets replaced
// - Failed program: rewrite page, copy earlier pages
// - Fix single-bit read errors with ECC; code only flags ecc_fixed and gives ecc_bit, rd_data uncorrected
// - ECC corrects one bit, detects two
// - Verify mismatch: replace or correct via ECC; no read-back verify is done after program
// - Watch ready/busy before reading data out
module nbm_host_ctrl #(
	parameter int NBLK        = 2048,
	parameter int BW          = 11,
	parameter int LOG_BLKS    = 2013,
	parameter int T_PROG_CYC  = `NBM_T_PROG_CYC,
	parameter int T_ERASE_CYC = `NBM_T_ERASE_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Flash pins
	output var  logic              fl_cle,
	output var  logic              fl_ale,
	output var  logic              fl_ce_n,
	output var  logic              fl_we_n,
	output var  logic              fl_re_n,
	output var  logic              fl_wp_n,
	output var  logic [7:0]        fl_io_out,
	output var  logic              fl_io_oe_n,
	input  wire logic [7:0]        fl_io_in,
	input  wire logic              fl_rb,
	// Operation request
	input  wire logic              op_valid,
	input  wire nbm_pkg::nbm_op_t  op_code,
	input  wire logic [BW-1:0]     op_block,
	input  wire logic [4:0]        op_page,
	output var  logic              op_ready,
	// Program data
	input  wire logic [7:0]        wr_data,
	input  wire logic              wr_valid,
	output var  logic              wr_ready,
	output var  logic              resend,
	// Read data and result
	output var  logic [7:0]        rd_data,
	output var  logic              rd_valid,
	output var  logic              done,
	output var  logic              fail,
	output var  logic              timeout,
	output var  logic              remapped,
	output var  logic              ecc_fixed,
	output var  logic              ecc_uncorr,
	output var  logic [11:0]       ecc_bit,
	output var  logic              scan_done,
	output var  logic [BW:0]       bad_count
);
	import nbm_pkg::*;

	// Micro-step table for each job
	function automatic nbm_step_t step_fn(input nbm_job_t j, input logic [3:0] s);
		nbm_step_t r;
		r = '{K_END, 8'h00};
		case (j)
			J_INIT:  case (s)
				4'h0: r = '{K_CMD, `NBM_CMD_RESET};
				4'h1: r = '{K_WAIT, 8'h00};
				default: r = '{K_END, 8'h00};
			endcase
			J_SCAN, J_READ: case (s)
				4'h0: r = '{K_CMD, (j == J_SCAN) ? `NBM_CMD_READ_SPARE : `NBM_CMD_READ_MAIN};
				4'h1: r = '{K_ADDR, 8'h00};
				4'h2: r = '{K_WAIT, 8'h00};
				4'h3: r = '{K_RDATA, 8'h00};
				default: r = '{K_END, 8'h00};
			endcase
			J_PROG:  case (s)
				4'h0: r = '{K_CMD, `NBM_CMD_READ_MAIN};
				4'h1: r = '{K_CMD, `NBM_CMD_PROG_SETUP};
				4'h2: r = '{K_ADDR, 8'h00};
				4'h3: r = '{K_WDATA, 8'h00};
				4'h4: r = '{K_CMD, `NBM_CMD_PROG_GO};
				4'h5: r = '{K_WAIT, 8'h00};
				4'h6: r = '{K_CMD, `NBM_CMD_STATUS};
				4'h7: r = '{K_STAT, 8'h00};
				default: r = '{K_END, 8'h00};
			endcase
			J_ERASE: case (s)
				4'h0: r = '{K_CMD, `NBM_CMD_ERASE_SETUP};
				4'h1: r = '{K_ROW, 8'h00};
				4'h2: r = '{K_CMD, `NBM_CMD_ERASE_GO};
				4'h3: r = '{K_WAIT, 8'h00};
				4'h4: r = '{K_CMD, `NBM_CMD_STATUS};
				4'h5: r = '{K_STAT, 8'h00};
				default: r = '{K_END, 8'h00};
			endcase
			J_COPY:  case (s)
				4'h0: r = '{K_CMD, `NBM_CMD_READ_MAIN};
				4'h1: r = '{K_ADDR, 8'h00};
				4'h2: r = '{K_WAIT, 8'h00};
				4'h3: r = '{K_CMD, `NBM_CMD_COPY_DEST};
				4'h4: r = '{K_ADDRD, 8'h00};
				4'h5: r = '{K_CMD, `NBM_CMD_PROG_GO};
				4'h6: r = '{K_WAIT, 8'h00};
				4'h7: r = '{K_CMD, `NBM_CMD_STATUS};
				4'h8: r = '{K_STAT, 8'h00};
				default: r = '{K_END, 8'h00};
			endcase
			default: r = '{K_END, 8'h00};
		endcase
		return r;
	endfunction : step_fn

	// Bit-position code of one byte: low 12 bits XOR of set-bit indices, top bit parity
	function automatic logic [12:0] ecc_fn(input logic [8:0] col, input logic [7:0] d);
		logic [12:0] r;
		r = 13'h0;
		for (int i = 0; i < 8; i++) begin
			if (d[i]) begin
				r = r ^ {1'b1, col, 3'(i)};
			end
		end
		return r;
	endfunction : ecc_fn

	nbm_state_t     st_reg, st_next;
	nbm_job_t       job_reg, job_next;
	nbm_op_t        op_reg, op_next;
	nbm_step_t      stp;
	logic [3:0]     seq_reg, seq_next;
	logic [2:0]     ph_reg, ph_next;
	logic [9:0]     cnt_reg, cnt_next;
	logic [19:0]    tmr_reg, tmr_next, lim;
	logic [BW-1:0]  phys_reg, phys_next, old_reg, old_next, log_reg, log_next, scan_reg, scan_next;
	logic [4:0]     page_reg, page_next, cp_reg, cp_next;
	logic [BW:0]    good_reg, good_next, spare_reg, spare_next, bad_next;
	logic           init_reg, init_next, repl_reg, repl_next, lkspare_reg, lkspare_next, abort_reg, abort_next;
	logic [7:0]     byte_reg, byte_next, dat_reg, dat_next;
	logic [12:0]    ecc_reg, ecc_next;
	logic [15:0]    eccst_reg, eccst_next, row_a, row_d;
	logic           cle_next, ale_next, ce_n_next, we_n_next, re_n_next, oe_n_next, ready_next, wrr_next;
	logic           resend_next, rdv_next, done_next, fail_next, to_next, remap_next, fix_next, unc_next;
	logic [7:0]     io_next, rdd_next;
	logic [11:0]    bit_next, syn;
	logic           map_we, lo, wr_kind, xfer_last, stat_fail, mark_bad;
	logic [BW-1:0]  map_wa, map_wd, map_ra, map_rd;
	logic [7:0]     io_s1, io_s2;
	logic           rb_s1, rb_s2;

	nbm_map_ram #(.DW(BW), .AW(BW)) u_map (
		.clk     (clk),
		.wr_en   (map_we),
		.wr_addr (map_wa),
		.wr_data (map_wd),
		.rd_addr (map_ra),
		.rd_data (map_rd)
	);

	// Pin inputs cross in from the flash: two flops before any logic reads them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else begin
			io_s1 <= fl_io_in;
			io_s2 <= io_s1;
			rb_s1 <= fl_rb;
			rb_s2 <= rb_s1;
		end
	end

	// Sequencer next-state logic
	always_comb begin
		st_next = st_reg; job_next = job_reg; op_next = op_reg; seq_next = seq_reg; ph_next = ph_reg;
		cnt_next = cnt_reg; tmr_next = tmr_reg; phys_next = phys_reg; old_next = old_reg; log_next = log_reg;
		scan_next = scan_reg; page_next = page_reg; cp_next = cp_reg; good_next = good_reg; spare_next = spare_reg;
		bad_next = bad_count; init_next = init_reg; repl_next = repl_reg; lkspare_next = lkspare_reg;
		abort_next = abort_reg; byte_next = byte_reg; dat_next = dat_reg; ecc_next = ecc_reg; eccst_next = eccst_reg;
		ready_next = op_ready; wrr_next = wr_ready; resend_next = resend; rdv_next = 1'b0; rdd_next = rd_data;
		done_next = 1'b0; fail_next = fail; to_next = timeout; remap_next = remapped; fix_next = ecc_fixed;
		unc_next = ecc_uncorr; bit_next = ecc_bit; map_we = 1'b0; map_wa = log_reg; map_wd = phys_reg;
		map_ra = lkspare_reg ? spare_reg[BW-1:0] : log_reg;
		stp = step_fn(job_reg, seq_reg);
		wr_kind = (stp.kind == K_WDATA);
		xfer_last = (job_reg == J_SCAN || stp.kind == K_STAT) ? 1'b1 : (cnt_reg == `NBM_XFER_LAST);
		stat_fail = byte_reg[`NBM_STAT_FAIL_BIT];
		mark_bad = (scan_reg != '0) && (byte_reg != `NBM_ERASED);
		syn = eccst_reg[11:0] ^ ecc_reg[11:0];
		row_a = (job_reg == J_COPY) ? 16'({old_reg, cp_reg}) : 16'({phys_reg, page_reg});
		row_d = 16'({phys_reg, cp_reg});
		// Wait limit: reset, page load, program or erase busy time
		case (job_reg)
			J_INIT:  lim = 20'(`NBM_T_RST_CYC);
			J_PROG:  lim = 20'(T_PROG_CYC);
			J_ERASE: lim = 20'(T_ERASE_CYC);
			J_COPY:  lim = (seq_reg == 4'h6) ? 20'(T_PROG_CYC) : 20'(`NBM_T_LOAD_CYC);
			default: lim = 20'(`NBM_T_LOAD_CYC);
		endcase
		case (st_reg)
			S_IDLE: begin
				if (!init_reg) begin
					job_next = J_INIT; seq_next = 4'h0; st_next = S_STEP; ready_next = 1'b0;
				end else if (op_valid && op_ready) begin
					ready_next = 1'b0; op_next = op_code; log_next = op_block; page_next = op_page;
					fail_next = 1'b0; to_next = 1'b0; remap_next = 1'b0; fix_next = 1'b0; unc_next = 1'b0;
					// Out-of-range logical blocks never reach the flash
					if (op_block >= BW'(LOG_BLKS) || 32'(op_block) >= 32'(good_reg) || op_code > OP_ERASE) begin
						done_next = 1'b1; fail_next = 1'b1; ready_next = 1'b1;
					end else begin
						st_next = S_LOOK; lkspare_next = 1'b0;
					end
				end
			end
			S_LOOK: st_next = S_TAKE;
			S_TAKE: begin
				if (lkspare_reg) begin
					// Fresh spare is erased before use; the failed block drops out of the map
					if (!repl_reg) begin
						old_next = phys_reg;
					end
					phys_next = map_rd; spare_next = spare_reg + 1'b1; bad_next = bad_count + 1'b1;
					repl_next = 1'b1; job_next = J_ERASE;
				end else begin
					phys_next = map_rd;
					job_next = (op_reg == OP_READ) ? J_READ : (op_reg == OP_PROG) ? J_PROG : J_ERASE;
				end
				seq_next = 4'h0; st_next = S_STEP;
			end
			S_STEP: begin
				ph_next = 3'h0; cnt_next = 10'h0; tmr_next = 20'h0;
				case (stp.kind)
					K_CMD: st_next = S_CMD;
					K_ADDR, K_ADDRD, K_ROW: st_next = S_ADDR;
					K_WDATA: begin
						st_next = S_XFER; wrr_next = 1'b1; ecc_next = 13'h0;
					end
					K_RDATA, K_STAT: begin
						st_next = S_XFER; ecc_next = 13'h0;
					end
					K_WAIT: st_next = S_WAIT;
					default: st_next = S_GAP;
				endcase
			end
			S_CMD, S_ADDR: begin
				ph_next = ph_reg + 3'h1;
				if (ph_reg == `NBM_CYC_LAST) begin
					ph_next = 3'h0;
					cnt_next = cnt_reg + 10'h1;
					if (st_reg == S_CMD || cnt_reg == ((stp.kind == K_ROW) ? 10'h1 : 10'h2)) begin
						seq_next = seq_reg + 4'h1; st_next = S_STEP;
					end
				end
			end
			S_XFER: begin
				if (ph_reg == 3'h0 && wr_kind && cnt_reg < `NBM_PAGE_BYTES) begin
					// Hold with strobes high until the user offers the next byte
					if (wr_valid) begin
						dat_next = wr_data; wrr_next = 1'b0; ph_next = 3'h1;
						ecc_next = ecc_reg ^ ecc_fn(cnt_reg[8:0], wr_data);
					end
				end else begin
					if (ph_reg == 3'h0 && wr_kind) begin
						dat_next = (cnt_reg == `NBM_PAGE_BYTES) ? ecc_reg[7:0] : {ecc_reg[12], 3'h0, ecc_reg[11:8]};
					end
					if (ph_reg == `NBM_SAMPLE_PH && !wr_kind) begin
						byte_next = io_s2;
						if (job_reg == J_READ && cnt_reg < `NBM_PAGE_BYTES) begin
							rdd_next = io_s2; rdv_next = 1'b1;
							ecc_next = ecc_reg ^ ecc_fn(cnt_reg[8:0], io_s2);
						end else if (job_reg == J_READ) begin
							eccst_next = (cnt_reg == `NBM_PAGE_BYTES) ? {eccst_reg[15:8], io_s2} : {io_s2, eccst_reg[7:0]};
						end
					end
					ph_next = ph_reg + 3'h1;
					if (ph_reg == `NBM_CYC_LAST) begin
						ph_next = 3'h0;
						cnt_next = cnt_reg + 10'h1;
						wrr_next = wr_kind && (cnt_reg + 10'h1 < `NBM_PAGE_BYTES);
						if (xfer_last) begin
							seq_next = seq_reg + 4'h1; st_next = S_STEP; wrr_next = 1'b0;
						end
					end
				end
			end
			S_WAIT: begin
				tmr_next = tmr_reg + 20'h1;
				// Busy shows only after the write-to-busy delay plus the input flop lag
				if (tmr_reg >= 20'(`NBM_T_WB_CYC + `NBM_SYNC_LAG) && rb_s2) begin
					seq_next = seq_reg + 4'h1; st_next = S_STEP;
				end else if (tmr_reg >= lim) begin
					to_next = 1'b1; fail_next = 1'b1; abort_next = 1'b1; st_next = S_GAP; tmr_next = 20'h0;
				end
			end
			S_GAP: begin
				tmr_next = tmr_reg + 20'h1;
				// Select stays high long enough to end any sequential read
				if (tmr_reg >= 20'(`NBM_SEL_HOLD_CYC - 1)) begin
					tmr_next = 20'h0;
					if (abort_reg) begin
						abort_next = 1'b0; repl_next = 1'b0; resend_next = 1'b0; st_next = S_IDLE;
						done_next = init_reg; ready_next = init_reg;
					end else begin
						st_next = S_NEXT;
					end
				end
			end
			S_NEXT: begin
				st_next = S_STEP; seq_next = 4'h0;
				case (job_reg)
					J_INIT: begin
						job_next = J_SCAN; scan_next = '0; phys_next = '0; page_next = 5'h0;
						good_next = '0; bad_next = '0;
					end
					J_SCAN: begin
						// Markers are only read; the scan issues no erase at all
						if (!mark_bad && page_reg == 5'h0) begin
							page_next = 5'h1;
						end else begin
							if (!mark_bad) begin
								map_we = 1'b1; map_wa = good_reg[BW-1:0]; map_wd = scan_reg;
								good_next = good_reg + 1'b1;
							end else begin
								bad_next = bad_count + 1'b1;
							end
							page_next = 5'h0;
							if (32'(scan_reg) == NBLK - 1) begin
								init_next = 1'b1; spare_next = (BW+1)'(LOG_BLKS); st_next = S_IDLE; ready_next = 1'b1;
							end else begin
								scan_next = scan_reg + 1'b1; phys_next = scan_reg + 1'b1;
							end
						end
					end
					J_READ: begin
						// Erased pages carry no code; otherwise one flip is located, two are flagged
						if (eccst_reg != `NBM_ECC_ERASED) begin
							fix_next = eccst_reg[15] ^ ecc_reg[12];
							unc_next = !(eccst_reg[15] ^ ecc_reg[12]) && syn != 12'h0;
							fail_next = !(eccst_reg[15] ^ ecc_reg[12]) && syn != 12'h0;
							bit_next = syn;
						end
						done_next = 1'b1; ready_next = 1'b1; st_next = S_IDLE;
					end
					J_PROG, J_COPY, J_ERASE: begin
						if (stat_fail) begin
							// Failed block is retired and a spare taken in its place; with no spare left the job fails
							if (spare_reg >= good_reg) begin
								fail_next = 1'b1; done_next = 1'b1; ready_next = 1'b1; st_next = S_IDLE;
								repl_next = 1'b0; resend_next = 1'b0;
							end else begin
								lkspare_next = 1'b1; st_next = S_LOOK; resend_next = 1'b0;
							end
						end else if (repl_reg && job_reg == J_ERASE && op_reg == OP_PROG) begin
							job_next = J_PROG; resend_next = 1'b1; cp_next = 5'h0;
						end else if (repl_reg && job_reg != J_ERASE && cp_reg < page_reg) begin
							if (job_reg == J_COPY) begin
								cp_next = cp_reg + 5'h1;
							end
							job_next = (job_reg == J_COPY && cp_reg + 5'h1 == page_reg) ? J_PROG : J_COPY;
							resend_next = 1'b0;
							if (job_reg == J_COPY && cp_reg + 5'h1 == page_reg) begin
								cp_next = page_reg; st_next = S_NEXT;
							end
						end else begin
							if (repl_reg) begin
								map_we = 1'b1; map_wa = log_reg; map_wd = phys_reg;
								remap_next = 1'b1;
							end
							repl_next = 1'b0; resend_next = 1'b0; done_next = 1'b1; ready_next = 1'b1;
							st_next = S_IDLE;
						end
					end
					default: st_next = S_IDLE;
				endcase
			end
			default: st_next = S_IDLE;
		endcase
		// Pin levels for the coming cycle
		lo = (st_next == S_CMD || st_next == S_ADDR || st_next == S_XFER)
			&& ph_next >= `NBM_STROBE_FIRST && ph_next <= `NBM_STROBE_LAST;
		cle_next = (st_next == S_CMD);
		ale_next = (st_next == S_ADDR);
		we_n_next = !(lo && (st_next != S_XFER || wr_kind));
		re_n_next = !(lo && st_next == S_XFER && !wr_kind);
		ce_n_next = (st_next == S_IDLE || st_next == S_GAP || st_next == S_LOOK || st_next == S_TAKE
			|| st_next == S_NEXT);
		oe_n_next = !(st_next == S_CMD || st_next == S_ADDR || (st_next == S_XFER && wr_kind));
		case (st_next)
			S_CMD:  io_next = stp.cmd;
			S_ADDR: case (cnt_next[1:0])
				2'h0:    io_next = (stp.kind == K_ROW) ? row_a[7:0] : (job_reg == J_SCAN) ? `NBM_MARK_SPARE_COL : 8'h00;
				2'h1:    io_next = (stp.kind == K_ROW) ? row_a[15:8] : (stp.kind == K_ADDRD) ? row_d[7:0] : row_a[7:0];
				default: io_next = (stp.kind == K_ADDRD) ? row_d[15:8] : row_a[15:8];
			endcase
			default: io_next = dat_next;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= S_IDLE; job_reg <= J_INIT; op_reg <= OP_READ; seq_reg <= 4'h0; ph_reg <= 3'h0;
			cnt_reg <= 10'h0; tmr_reg <= 20'h0; phys_reg <= '0; old_reg <= '0; log_reg <= '0; scan_reg <= '0;
			page_reg <= 5'h0; cp_reg <= 5'h0; good_reg <= '0; spare_reg <= '0; bad_count <= '0;
			init_reg <= 1'b0; repl_reg <= 1'b0; lkspare_reg <= 1'b0; abort_reg <= 1'b0; byte_reg <= 8'h00;
			dat_reg <= 8'h00; ecc_reg <= 13'h0; eccst_reg <= 16'h0;
			fl_cle <= 1'b0; fl_ale <= 1'b0; fl_ce_n <= 1'b1; fl_we_n <= 1'b1; fl_re_n <= 1'b1; fl_wp_n <= 1'b0;
			fl_io_out <= 8'h00; fl_io_oe_n <= 1'b1; op_ready <= 1'b0; wr_ready <= 1'b0; resend <= 1'b0;
			rd_data <= 8'h00; rd_valid <= 1'b0; done <= 1'b0; fail <= 1'b0; timeout <= 1'b0; remapped <= 1'b0;
			ecc_fixed <= 1'b0; ecc_uncorr <= 1'b0; ecc_bit <= 12'h0; scan_done <= 1'b0;
		end else begin
			st_reg <= st_next; job_reg <= job_next; op_reg <= op_next; seq_reg <= seq_next; ph_reg <= ph_next;
			cnt_reg <= cnt_next; tmr_reg <= tmr_next; phys_reg <= phys_next; old_reg <= old_next;
			log_reg <= log_next; scan_reg <= scan_next; page_reg <= page_next; cp_reg <= cp_next;
			good_reg <= good_next; spare_reg <= spare_next; bad_count <= bad_next; init_reg <= init_next;
			repl_reg <= repl_next; lkspare_reg <= lkspare_next; abort_reg <= abort_next; byte_reg <= byte_next;
			dat_reg <= dat_next; ecc_reg <= ecc_next; eccst_reg <= eccst_next;
			fl_cle <= cle_next; fl_ale <= ale_next; fl_ce_n <= ce_n_next; fl_we_n <= we_n_next;
			fl_re_n <= re_n_next; fl_wp_n <= init_next; fl_io_out <= io_next; fl_io_oe_n <= oe_n_next;
			op_ready <= ready_next; wr_ready <= wrr_next; resend <= resend_next; rd_data <= rdd_next;
			rd_valid <= rdv_next; done <= done_next; fail <= fail_next; timeout <= to_next;
			remapped <= remap_next; ecc_fixed <= fix_next; ecc_uncorr <= unc_next; ecc_bit <= bit_next;
			scan_done <= init_next;
		end
	end

endmodule : nbm_host_ctrl

`default_nettype wire

// file: logic/nbm_cfg.svh
`ifndef NBM_CFG_SVH
`define NBM_CFG_SVH

// Clock rate and derived cycle counts
`define NBM_CLK_MHZ          40
`define NBM_T_RST_US         5
`define NBM_T_LOAD_US        10
`define NBM_T_PROG_US        500
`define NBM_T_ERASE_US       3000
`define NBM_T_WB_NS          100
`define NBM_T_SEL_HOLD_NS    100
`define NBM_T_RST_CYC        (`NBM_T_RST_US * `NBM_CLK_MHZ)
`define NBM_T_LOAD_CYC       (`NBM_T_LOAD_US * `NBM_CLK_MHZ)
`define NBM_T_PROG_CYC       (`NBM_T_PROG_US * `NBM_CLK_MHZ)
`define NBM_T_ERASE_CYC      (`NBM_T_ERASE_US * `NBM_CLK_MHZ)
`define NBM_T_WB_CYC         ((`NBM_T_WB_NS * `NBM_CLK_MHZ + 999) / 1000)
`define NBM_SEL_HOLD_CYC     ((`NBM_T_SEL_HOLD_NS * `NBM_CLK_MHZ) / 1000 + 1)
`define NBM_SYNC_LAG         2

// Pin cycle shape: strobe low in phases 1..3, read sample in phase 5
`define NBM_CYC_LAST         3'h5
`define NBM_STROBE_FIRST     3'h1
`define NBM_STROBE_LAST      3'h3
`define NBM_SAMPLE_PH        3'h5

// Command bytes
`define NBM_CMD_RESET        8'hff
`define NBM_CMD_READ_MAIN    8'h00
`define NBM_CMD_READ_SPARE   8'h50
`define NBM_CMD_PROG_SETUP   8'h80
`define NBM_CMD_PROG_GO      8'h10
`define NBM_CMD_ERASE_SETUP  8'h60
`define NBM_CMD_ERASE_GO     8'hd0
`define NBM_CMD_STATUS       8'h70
`define NBM_CMD_COPY_DEST    8'h8a

// Page layout
`define NBM_PAGE_BYTES       10'h200
`define NBM_XFER_LAST        10'h201
`define NBM_MARK_SPARE_COL   8'h05
`define NBM_ERASED           8'hff
`define NBM_ECC_ERASED       16'hffff
`define NBM_STAT_FAIL_BIT    0
`define NBM_PG_BITS          5

`endif

// file: logic/nbm_pkg.sv
package nbm_pkg;

	// Sequencer states, one-hot
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_LOOK = 10'h002,
		S_TAKE = 10'h004,
		S_STEP = 10'h008,
		S_CMD  = 10'h010,
		S_ADDR = 10'h020,
		S_XFER = 10'h040,
		S_WAIT = 10'h080,
		S_GAP  = 10'h100,
		S_NEXT = 10'h200
	} nbm_state_t;

	// Flash jobs run by the sequencer
	typedef enum logic [2:0] {J_INIT, J_SCAN, J_READ, J_PROG, J_ERASE, J_COPY} nbm_job_t;

	// Kinds of micro-step within a job
	typedef enum logic [3:0] {K_CMD, K_ADDR, K_ADDRD, K_ROW, K_WDATA, K_RDATA, K_WAIT, K_STAT, K_END} nbm_kind_t;

	// User operations
	typedef enum logic [1:0] {OP_READ = 2'h0, OP_PROG = 2'h1, OP_ERASE = 2'h2} nbm_op_t;

	typedef struct packed {
		nbm_kind_t   kind;
		logic [7:0]  cmd;
	} nbm_step_t;

endpackage : nbm_pkg

// file: logic/nbm_map_ram.sv
`timescale 1ns/10ps
`default_nettype none

// Logical-to-physical block map, registered read
module nbm_map_ram #(
	parameter int DW = 11,
	parameter int AW = 11
) (
	// Clock
	input  wire logic          clk,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0] rd_addr,
	output var  logic [DW-1:0] rd_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// No reset: every entry in use is written by the scan before it is read
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : nbm_map_ram

`default_nettype wire

// file: tb/nbm_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Port checks on the host controller
module nbm_host_chk #(parameter int BW = 11, parameter int LOG_BLKS = 2013) (
	// Clock and reset
	input wire logic clk, reset_n,
	// Flash pins
	input wire logic fl_ce_n, fl_re_n, fl_wp_n, fl_io_oe_n, fl_rb,
	// User side
	input wire logic op_valid, op_ready, done, fail, remapped, scan_done, rd_valid,
	input wire nbm_pkg::nbm_op_t op_code,
	input wire logic [BW-1:0] op_block
);
	import nbm_pkg::*;
	// Requests that must never reach the part
	wire logic refuse = op_valid && op_ready && (op_code == nbm_op_t'(2'h3) || op_block >= LOG_BLKS);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Markers stay protected until the table exists
	a_wp_scan: assert property (!scan_done |-> !fl_wp_n)
		else $error("wp released early");
	a_ready_scan: assert property (op_ready |-> scan_done)
		else $error("ready before scan end");
	a_read_ready: assert property (!fl_rb |-> fl_re_n)
		else $error("read strobe while busy");
	a_no_drive_read: assert property (!fl_re_n |-> fl_io_oe_n)
		else $error("io driven in read");
	// Five clocks is 125 ns, enough to end a running read
	a_ce_gap: assert property ($rose(fl_ce_n) && scan_done |-> fl_ce_n [*5])
		else $error("select gap short");
	a_refuse_done: assert property (refuse |-> ##1 (done && fail))
		else $error("refusal not answered");
	a_refuse_quiet: assert property (refuse |-> fl_ce_n [*4])
		else $error("refusal touched part");
	a_remap_done: assert property ($rose(remapped) |-> ##[0:2] done)
		else $error("remap without done");
	c_scan: cover property ($rose(scan_done));
	c_read: cover property (rd_valid);
	c_remap: cover property (done && remapped);
endmodule : nbm_host_chk
bind nbm_host_ctrl nbm_host_chk #(.BW(BW), .LOG_BLKS(LOG_BLKS)) i_nbm_host_chk (.*);
`default_nettype wire

// file: tb/nbm_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// Flash part: latches on write strobe rise, drives on read strobe
module nbm_flash_model #(parameter int BAD = 3) (
	// Pins
	input wire logic cle, ale, ce_n, we_n, re_n,
	input wire logic [7:0] din,
	output var logic [7:0] dout,
	output var logic rb,
	// Scenario control and observation
	input wire logic [10:0] fail_blk,
	output var logic [10:0] last_blk,
	output var logic hit_bad
);
	logic [7:0] cmd = 8'h00, q = 8'h00;
	logic [15:0] row = 16'h0000;
	logic st_fail = 1'b0;
	int na = 0;
	initial begin
		rb = 1'b1;
		hit_bad = 1'b0;
		last_blk = 11'h000;
	end
	// Busy falls well inside 100 ns of the strobe
	task automatic busy(input int n);
		last_blk = row[15:5];
		fork begin #5 rb = 1'b0; #(n) rb = 1'b1; end join_none
	endtask : busy
	// Command and address latch
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			cmd = din;
			na = 0;
			if (din == 8'hff) busy(2000);
			if (din == 8'h10 || din == 8'hd0) begin
				st_fail = (row[15:5] == fail_blk); // Fails only where a scenario asks
				hit_bad |= (row[15:5] == BAD);
				busy(3000);
			end
		end else if (ale) begin
			row = {din, row[15:8]};
			na++;
			if (na == 3 && (cmd == 8'h00 || cmd == 8'h50)) busy(5000);
		end
	end
	// Erased cells read all-ones; block zero is never the marked one
	always @(negedge re_n) q = (cmd == 8'h70) ? {7'h00, st_fail} :
		(cmd == 8'h50 && row[15:5] == BAD && row[4:0] == 5'h00) ? 8'h00 : 8'hff;
	// Released bus shows the inverse, so a late sample cannot pass by luck
	assign dout = (!ce_n && !re_n) ? q : ~q;
endmodule : nbm_flash_model
`default_nettype wire

// file: tb/nbm_host_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nbm_host_ctrl_tb;
	import nbm_pkg::*;
	logic clk = 0, reset_n = 0, op_valid = 0;
	logic cle, ale, ce_n, we_n, re_n, wp_n, oe_n, rb, op_ready, done, fail, rd_valid, remapped, scan_done, hit_bad;
	logic wr_valid = 0, wr_ready, resend, timeout, ecc_fixed, ecc_uncorr;
	logic [7:0] io_out, din, dout, rd_data, wr_data = 8'h00;
	logic [4:0] op_page = 5'h02;
	logic [2:0] op_block = 3'h0;
	logic [3:0] bad_count;
	logic [10:0] fail_blk = 11'h7ff, last_blk;
	nbm_op_t op_code = OP_READ;
	int n_errors = 0, samples_checked = 0, cyc = 0, nrd = 0;
	assign din = oe_n ? dout : io_out; // Wire level from both drivers
	nbm_host_ctrl #(.NBLK(8), .BW(3), .LOG_BLKS(6), .T_PROG_CYC(400), .T_ERASE_CYC(400)) i_nbm_host_ctrl (
		.clk, .reset_n, .fl_cle(cle), .fl_ale(ale), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_re_n(re_n),
		.fl_wp_n(wp_n), .fl_io_out(io_out), .fl_io_oe_n(oe_n), .fl_io_in(din), .fl_rb(rb), .op_valid,
		.op_code, .op_block, .op_page, .op_ready, .wr_data, .wr_valid, .wr_ready,
		.resend, .rd_data, .rd_valid, .done, .fail, .timeout, .remapped, .ecc_fixed, .ecc_uncorr,
		.ecc_bit(), .scan_done, .bad_count);
	nbm_flash_model i_nbm_flash_model (.cle, .ale, .ce_n, .we_n, .re_n, .din, .dout, .rb, .fail_blk,
		.last_blk, .hit_bad);
	initial forever #12.5 clk = ~clk;
	// Run needs about 14000 cycles; cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// One request, then collect bytes until completion
	task automatic run(input nbm_op_t c, input logic [2:0] b);
		op_code = c;
		op_block = b;
		op_valid = 1;
		nrd = 0;
		while (op_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		op_valid = 0;
		while (done !== 1'b1) begin
			if (rd_valid === 1'b1) begin
				nrd++;
				chk(rd_data, 8'hff);
			end
			// Program bytes taken go into the same tally
			if (wr_ready === 1'b1) nrd++;
			@(negedge clk);
		end
		// Let an edge pass so a following call never flips op_valid in one step
		@(negedge clk);
	endtask : run
	task automatic t_scan;
		while (op_ready !== 1'b1) @(negedge clk);
		chk({scan_done, wp_n}, 2'b11);
		chk(bad_count, 1);
	endtask : t_scan
	// Block zero, then a block that sits past the marked one
	task automatic t_read;
		for (int b = 0; b < 4; b += 3) begin
			run(OP_READ, 3'(b));
			chk(nrd, 512);
			chk({timeout, fail, ecc_fixed, ecc_uncorr}, 0);
			chk(last_blk, b == 3 ? 4 : 0);
		end
	endtask : t_read
	// Program streams one steady byte, valid held; the part reports pass
	task automatic t_prog;
		wr_data = 8'h5a;
		wr_valid = 1;
		run(OP_PROG, 3'h1);
		wr_valid = 0;
		chk(nrd, 512);
		chk({timeout, fail, resend, last_blk}, {3'b000, 11'h001});
	endtask : t_prog
	task automatic t_refuse;
		run(nbm_op_t'(2'h3), 3'h0);
		chk(fail, 1);
		run(OP_READ, 3'h6);
		chk({fail, 7'(nrd)}, 8'h80);
	endtask : t_refuse
	// Erase fails on the part, spare takes over and is used afterwards
	task automatic t_erase_fail;
		fail_blk = 11'h005;
		run(OP_ERASE, 3'h4);
		chk({fail, remapped, last_blk}, {2'b01, 11'h007});
		chk(bad_count, 2);
		run(OP_ERASE, 3'h4);
		chk({fail, remapped, last_blk}, {2'b00, 11'h007});
		chk(hit_bad, 0);
	endtask : t_erase_fail
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1;
		t_scan();
		t_read();
		t_prog();
		t_refuse();
		t_erase_fail();
		print_verdict();
	end
endmodule : nbm_host_ctrl_tb
`default_nettype wire
